// *** can_bus_model.sv ***
module can_bus_model (
    input wire logic clk,
    output logic bit_start,
    output logic sof_bit,
    output logic eof_last_bit,
    output logic frame_ok,
    output logic tx_own,
    output logic rx_own
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bus starts idle with every strobe low.
    initial begin
        {bit_start, sof_bit, eof_last_bit, frame_ok, tx_own, rx_own} = 6'h00;
    end
    // One bit time per cycle, the fastest pace the counter accepts.
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge clk);
            bit_start <= 1'b1;
        end
        @(posedge clk);
        bit_start <= 1'b0;
    endtask
    // Ten bit times per frame; no owner flag means a foreign frame.
    task automatic frame(input logic tx, input logic rx);
        @(posedge clk);
        sof_bit <= 1'b1;
        repeat (10) begin
            @(posedge clk);
            sof_bit <= 1'b0;
            bit_start <= 1'b1;
            @(posedge clk);
            bit_start <= 1'b0;
        end
        @(posedge clk);
        eof_last_bit <= 1'b1;
        @(posedge clk);
        eof_last_bit <= 1'b0;
        frame_ok <= 1'b1;
        tx_own <= tx;
        rx_own <= rx;
        @(posedge clk);
        frame_ok <= 1'b0;
        // Qualifiers flip after the frame, so stale values are never trusted.
        tx_own <= ~tx;
        rx_own <= ~rx;
        @(negedge clk);
    endtask
endmodule // can_bus_model

// *** can_fc_defines.vh ***
`ifndef CAN_FC_DEFINES_VH
`define CAN_FC_DEFINES_VH

// Register byte offsets on the AHB-Lite slave.
`define OFS_A_FC_CTRL 12'h000
`define OFS_B_FC_CTRL 12'h004
`define OFS_A_IRQ_ROUTE 12'h008
`define OFS_B_IRQ_ROUTE 12'h00C
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014
`define OFS_NODE_IRQ_EN 12'h018

// Counter control field positions.
`define FC_MODE_TS_BIT 3
`define FC_MODE_FOREIGN_BIT 0
`define FC_MODE_RX_BIT 1
`define FC_MODE_TX_BIT 2
`define FC_IE_BIT 6
`define FC_OV_BIT 7
`define FC_CTRL_RW_MASK 7'h4F

// Time-stamp mode values.
`define FC_MODE_TS_SOF 4'h8
`define FC_MODE_TS_EOF 4'h9

// Routing register layout.
`define ROUTE_ERR_LSB 0
`define ROUTE_LEC_LSB 4
`define ROUTE_TRX_LSB 8
`define ROUTE_OVF_LSB 12
`define ROUTE_RW_MASK 16'h7777
`define ROUTE_RESET 16'h0000

// Node interrupt enable bits.
`define NIE_ERR_BIT 0
`define NIE_LEC_BIT 1
`define NIE_SUCC_BIT 2

`endif

// *** can_frame_counter_irq_routing.v ***
`include "can_fc_defines.vh"

module can_frame_counter_irq_routing (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    a_bit_start,
    a_sof_bit,
    a_eof_last_bit,
    a_frame_ok,
    a_frame_tx_own,
    a_frame_rx_own,
    a_error_req,
    a_last_error_req,
    a_tx_ok_req,
    a_rx_ok_req,
    b_bit_start,
    b_sof_bit,
    b_eof_last_bit,
    b_frame_ok,
    b_frame_tx_own,
    b_frame_rx_own,
    b_error_req,
    b_last_error_req,
    b_tx_ok_req,
    b_rx_ok_req,
    a_captured_count_field,
    a_captured_count_valid,
    b_captured_count_field,
    b_captured_count_valid,
    a_time_stamp,
    b_time_stamp,
    can_irq_nodes,
    irq
);
    input wire hclk;
    input wire hresetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output wire hreadyout;
    output wire hresp;
    input wire a_bit_start;
    input wire a_sof_bit;
    input wire a_eof_last_bit;
    input wire a_frame_ok;
    input wire a_frame_tx_own;
    input wire a_frame_rx_own;
    input wire a_error_req;
    input wire a_last_error_req;
    input wire a_tx_ok_req;
    input wire a_rx_ok_req;
    input wire b_bit_start;
    input wire b_sof_bit;
    input wire b_eof_last_bit;
    input wire b_frame_ok;
    input wire b_frame_tx_own;
    input wire b_frame_rx_own;
    input wire b_error_req;
    input wire b_last_error_req;
    input wire b_tx_ok_req;
    input wire b_rx_ok_req;
    output reg [15:0] a_captured_count_field;
    output reg a_captured_count_valid;
    output reg [15:0] b_captured_count_field;
    output reg b_captured_count_valid;
    output wire [15:0] a_time_stamp;
    output wire [15:0] b_time_stamp;
    output wire [7:0] can_irq_nodes;
    output wire irq;

    reg [6:0] a_ctrl_r;
    reg [6:0] b_ctrl_r;
    reg [15:0] a_route_r;
    reg [15:0] b_route_r;
    reg [5:0] nie_r;
    reg [1:0] irq_status_r;
    reg [1:0] irq_mask_r;
    reg wr_pend_r;
    reg [11:0] wr_addr_r;
    wire [15:0] a_count;
    wire [15:0] b_count;
    wire [15:0] a_sof_cap;
    wire [15:0] b_sof_cap;
    wire a_ovf_flag;
    wire b_ovf_flag;
    wire a_ovf_pulse;
    wire b_ovf_pulse;
    wire a_ovf_clr;
    wire b_ovf_clr;
    wire [15:0] a_ctrl_rd;
    wire [15:0] b_ctrl_rd;
    wire [7:0] route_vec [0:7];
    wire [3:0] src_req [0:1];
    wire [2:0] src_sel [0:7];
    wire wr_now;
    wire rd_now;
    wire wr_a_ctrl;
    wire wr_b_ctrl;
    wire wr_a_route;
    wire wr_b_route;
    wire wr_status;
    wire wr_mask;
    wire wr_nie;
    wire [1:0] irq_set;
    integer k;

    // Every access finishes in its first data-phase cycle, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_now = wr_pend_r;
    assign rd_now = hsel & hready & htrans[1] & ~hwrite;

    // One write strobe per register, decoded once from the captured address phase.
    assign wr_a_ctrl = wr_now & (wr_addr_r == `OFS_A_FC_CTRL);
    assign wr_b_ctrl = wr_now & (wr_addr_r == `OFS_B_FC_CTRL);
    assign wr_a_route = wr_now & (wr_addr_r == `OFS_A_IRQ_ROUTE);
    assign wr_b_route = wr_now & (wr_addr_r == `OFS_B_IRQ_ROUTE);
    assign wr_status = wr_now & (wr_addr_r == `OFS_IRQ_STATUS);
    assign wr_mask = wr_now & (wr_addr_r == `OFS_IRQ_MASK);
    assign wr_nie = wr_now & (wr_addr_r == `OFS_NODE_IRQ_EN);

    // Control half read-back: count in the upper half, unused bits zero.
    assign a_ctrl_rd = {8'h00, a_ovf_flag, a_ctrl_r[6], 2'b00, a_ctrl_r[3:0]};
    assign b_ctrl_rd = {8'h00, b_ovf_flag, b_ctrl_r[6], 2'b00, b_ctrl_r[3:0]};

    // Writing a zero to the overflow flag acknowledges it.
    assign a_ovf_clr = wr_a_ctrl & ~hwdata[`FC_OV_BIT];
    assign b_ovf_clr = wr_b_ctrl & ~hwdata[`FC_OV_BIT];

    // One counter per node; the two share nothing but the clock and reset.
    frame_counter u_fc_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(a_ctrl_r[3:0]),
        .ovf_clear(a_ovf_clr),
        .bit_start(a_bit_start),
        .sof_bit(a_sof_bit),
        .eof_last_bit(a_eof_last_bit),
        .frame_ok(a_frame_ok),
        .frame_tx_own(a_frame_tx_own),
        .frame_rx_own(a_frame_rx_own),
        .count_r(a_count),
        .sample_r(a_time_stamp),
        .sof_capture_r(a_sof_cap),
        .overflow_flag_r(a_ovf_flag),
        .overflow_pulse(a_ovf_pulse)
    );

    // Node B mirrors node A with its own strobes and control half.
    frame_counter u_fc_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(b_ctrl_r[3:0]),
        .ovf_clear(b_ovf_clr),
        .bit_start(b_bit_start),
        .sof_bit(b_sof_bit),
        .eof_last_bit(b_eof_last_bit),
        .frame_ok(b_frame_ok),
        .frame_tx_own(b_frame_tx_own),
        .frame_rx_own(b_frame_rx_own),
        .count_r(b_count),
        .sample_r(b_time_stamp),
        .sof_capture_r(b_sof_cap),
        .overflow_flag_r(b_ovf_flag),
        .overflow_pulse(b_ovf_pulse)
    );

    // Gated requests per node: error, last error, tx/rx OK, overflow.
    assign src_req[0] = {a_ovf_pulse & a_ctrl_r[`FC_IE_BIT],
        (a_tx_ok_req | a_rx_ok_req) & nie_r[`NIE_SUCC_BIT],
        a_last_error_req & nie_r[`NIE_LEC_BIT],
        a_error_req & nie_r[`NIE_ERR_BIT]};
    assign src_req[1] = {b_ovf_pulse & b_ctrl_r[`FC_IE_BIT],
        (b_tx_ok_req | b_rx_ok_req) & nie_r[3 + `NIE_SUCC_BIT],
        b_last_error_req & nie_r[3 + `NIE_LEC_BIT],
        b_error_req & nie_r[3 + `NIE_ERR_BIT]};
    // Pointer fields, node A sources first and node B sources after them.
    assign src_sel[0] = a_route_r[`ROUTE_ERR_LSB +: 3];
    assign src_sel[1] = a_route_r[`ROUTE_LEC_LSB +: 3];
    assign src_sel[2] = a_route_r[`ROUTE_TRX_LSB +: 3];
    assign src_sel[3] = a_route_r[`ROUTE_OVF_LSB +: 3];
    assign src_sel[4] = b_route_r[`ROUTE_ERR_LSB +: 3];
    assign src_sel[5] = b_route_r[`ROUTE_LEC_LSB +: 3];
    assign src_sel[6] = b_route_r[`ROUTE_TRX_LSB +: 3];
    assign src_sel[7] = b_route_r[`ROUTE_OVF_LSB +: 3];

    // Eight steering units, four sources per node, each with its own pointer.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_route
            irq_router u_rt (
                .sel(src_sel[g]),
                .req(src_req[g / 4][g % 4]),
                .nodes(route_vec[g])
            );
        end
    endgenerate

    // Node lines are the OR of every source steered there.
    assign can_irq_nodes = route_vec[0] | route_vec[1] | route_vec[2] | route_vec[3]
        | route_vec[4] | route_vec[5] | route_vec[6] | route_vec[7];

    // Sticky overflow events for the block interrupt; set beats clear.
    assign irq_set = {b_ovf_pulse, a_ovf_pulse};
    assign irq = |(irq_status_r & irq_mask_r);

    // AHB address phase captured for the write data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= hsel & hready & htrans[1] & hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end

    // Read data registered at the address phase so it stands in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_now) begin
            case (haddr[11:0])
                `OFS_A_FC_CTRL: hrdata <= {a_count, a_ctrl_rd};
                `OFS_B_FC_CTRL: hrdata <= {b_count, b_ctrl_rd};
                `OFS_A_IRQ_ROUTE: hrdata <= {16'h0000, a_route_r};
                `OFS_B_IRQ_ROUTE: hrdata <= {16'h0000, b_route_r};
                `OFS_IRQ_STATUS: hrdata <= {30'h0000_0000, irq_status_r};
                `OFS_IRQ_MASK: hrdata <= {30'h0000_0000, irq_mask_r};
                `OFS_NODE_IRQ_EN: hrdata <= {26'h000_0000, nie_r};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Counter control halves; reserved bits are dropped so they read back as zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_ctrl_r <= 7'h00;
            b_ctrl_r <= 7'h00;
        end else begin
            if (wr_a_ctrl) begin
                a_ctrl_r <= hwdata[6:0] & `FC_CTRL_RW_MASK;
            end
            if (wr_b_ctrl) begin
                b_ctrl_r <= hwdata[6:0] & `FC_CTRL_RW_MASK;
            end
        end
    end

    // Node pointers; the gap bits are never stored, so no stale one can show.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_route_r <= `ROUTE_RESET;
            b_route_r <= `ROUTE_RESET;
        end else begin
            if (wr_a_route) begin
                a_route_r <= hwdata[15:0] & `ROUTE_RW_MASK;
            end
            if (wr_b_route) begin
                b_route_r <= hwdata[15:0] & `ROUTE_RW_MASK;
            end
        end
    end

    // Mask and node enables share no state with the counters, so they sit apart.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nie_r <= 6'h00;
            irq_mask_r <= 2'b00;
        end else begin
            if (wr_mask) begin
                irq_mask_r <= hwdata[1:0];
            end
            if (wr_nie) begin
                nie_r <= hwdata[5:0];
            end
        end
    end

    // Status bits: set by overflow, cleared by writing one; set wins.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_r <= 2'b00;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (irq_set[k]) begin
                    irq_status_r[k] <= 1'b1;
                end else if (wr_status && hwdata[k]) begin
                    irq_status_r[k] <= 1'b0;
                end
            end
        end
    end

    // At a correct transfer's end the SOF count goes to the message object.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_captured_count_field <= 16'h0000;
            a_captured_count_valid <= 1'b0;
            b_captured_count_field <= 16'h0000;
            b_captured_count_valid <= 1'b0;
        end else begin
            a_captured_count_valid <= a_frame_ok & (a_frame_tx_own | a_frame_rx_own);
            b_captured_count_valid <= b_frame_ok & (b_frame_tx_own | b_frame_rx_own);
            if (a_frame_ok) begin
                a_captured_count_field <= a_sof_cap;
            end
            if (b_frame_ok) begin
                b_captured_count_field <= b_sof_cap;
            end
        end
    end
endmodule // can_frame_counter_irq_routing

// *** can_frame_counter_irq_routing_asserts.sv ***
module can_frame_counter_irq_routing_asserts (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire hready,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire a_bit_start,
    input wire a_sof_bit,
    input wire a_eof_last_bit,
    input wire a_frame_ok,
    input wire a_frame_tx_own,
    input wire a_frame_rx_own,
    input wire b_bit_start,
    input wire b_sof_bit,
    input wire b_eof_last_bit,
    input wire b_frame_ok,
    input wire a_error_req,
    input wire a_last_error_req,
    input wire a_tx_ok_req,
    input wire a_rx_ok_req,
    input wire b_error_req,
    input wire b_last_error_req,
    input wire b_tx_ok_req,
    input wire b_rx_ok_req,
    input wire [15:0] a_captured_count_field,
    input wire a_captured_count_valid,
    input wire [15:0] a_time_stamp,
    input wire [15:0] b_time_stamp,
    input wire [7:0] can_irq_nodes,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_seen_r;
    wire [7:0] reqs = {b_rx_ok_req, b_tx_ok_req, b_last_error_req, b_error_req,
        a_rx_ok_req, a_tx_ok_req, a_last_error_req, a_error_req};
    wire strobe = a_bit_start | a_frame_ok | b_bit_start | b_frame_ok;
    // Remembers a write address phase, since its data lands one edge later.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_seen_r <= 1'b0;
        end else begin
            wr_seen_r <= hsel & hready & htrans[1] & hwrite;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_ROUTE_ONE: assert property ($onehot(reqs) && !strobe && !$past(strobe)
        |-> $onehot0(can_irq_nodes)) else $error("one source reached two nodes");
    AST_ROUTE_CAUSE: assert property (can_irq_nodes != 8'h00
        |-> reqs != 8'h00 || strobe || $past(strobe)) else $error("node without request");
    AST_TS_A: assert property ($changed(a_time_stamp)
        |-> $past(a_sof_bit || a_eof_last_bit)) else $error("stamp A moved off frame edge");
    AST_TS_B: assert property ($changed(b_time_stamp)
        |-> $past(b_sof_bit || b_eof_last_bit)) else $error("stamp B moved off frame edge");
    AST_CAP_VALID: assert property (a_captured_count_valid
        |-> $past(a_frame_ok && (a_frame_tx_own || a_frame_rx_own))) else $error("bad valid");
    AST_CAP_FIELD: assert property ($changed(a_captured_count_field)
        |-> $past(a_frame_ok)) else $error("capture moved without frame");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_seen_r))
        else $error("irq dropped without a write");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(strobe || wr_seen_r))
        else $error("irq rose without cause");
    COV_IRQ: cover property ($rose(irq));
    COV_CAP: cover property (a_captured_count_valid);
    COV_NODE: cover property (can_irq_nodes != 8'h00);
endmodule // can_frame_counter_irq_routing_asserts

bind can_frame_counter_irq_routing can_frame_counter_irq_routing_asserts
    i_can_frame_counter_irq_routing_asserts (.hclk, .hresetn, .hsel, .hready, .htrans,
    .hwrite, .a_bit_start, .a_sof_bit, .a_eof_last_bit, .a_frame_ok, .a_frame_tx_own,
    .a_frame_rx_own, .b_bit_start, .b_sof_bit, .b_eof_last_bit, .b_frame_ok, .a_error_req,
    .a_last_error_req, .a_tx_ok_req, .a_rx_ok_req, .b_error_req, .b_last_error_req,
    .b_tx_ok_req, .b_rx_ok_req, .a_captured_count_field, .a_captured_count_valid,
    .a_time_stamp, .b_time_stamp, .can_irq_nodes, .irq);

// *** can_frame_counter_irq_routing_test.sv ***
module can_frame_counter_irq_routing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] r;
    logic [7:0] reqs = 8'h00;
    logic [7:0] seen = 8'h00;
    logic [15:0] cnt;
    logic [15:0] cap;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, a_captured_count_valid, b_captured_count_valid, irq;
    wire [15:0] a_captured_count_field, b_captured_count_field, a_time_stamp, b_time_stamp;
    wire [7:0] can_irq_nodes;
    wire a_bit_start, a_sof_bit, a_eof_last_bit, a_frame_ok, a_frame_tx_own, a_frame_rx_own;
    wire b_bit_start, b_sof_bit, b_eof_last_bit, b_frame_ok, b_frame_tx_own, b_frame_rx_own;
    // One bus model per node, so both counters see real traffic.
    can_bus_model i_can_bus_model (.clk(hclk), .bit_start(a_bit_start), .sof_bit(a_sof_bit),
        .eof_last_bit(a_eof_last_bit), .frame_ok(a_frame_ok), .tx_own(a_frame_tx_own),
        .rx_own(a_frame_rx_own));
    can_bus_model i_can_bus_model_b (.clk(hclk), .bit_start(b_bit_start), .sof_bit(b_sof_bit),
        .eof_last_bit(b_eof_last_bit), .frame_ok(b_frame_ok), .tx_own(b_frame_tx_own),
        .rx_own(b_frame_rx_own));
    can_frame_counter_irq_routing i_can_frame_counter_irq_routing (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .a_bit_start, .a_sof_bit, .a_eof_last_bit, .a_frame_ok, .a_frame_tx_own,
        .a_frame_rx_own, .a_error_req(reqs[0]), .a_last_error_req(reqs[1]),
        .a_tx_ok_req(reqs[2]), .a_rx_ok_req(reqs[3]), .b_bit_start, .b_sof_bit,
        .b_eof_last_bit, .b_frame_ok, .b_frame_tx_own, .b_frame_rx_own,
        .b_error_req(reqs[4]), .b_last_error_req(reqs[5]), .b_tx_ok_req(reqs[6]),
        .b_rx_ok_req(reqs[7]), .a_captured_count_field, .a_captured_count_valid,
        .b_captured_count_field, .b_captured_count_valid, .a_time_stamp, .b_time_stamp,
        .can_irq_nodes, .irq);
    // Free-running clock and a sticky record of every node that fired.
    initial forever #4 hclk = ~hclk;
    always @(posedge hclk) seen <= seen | can_irq_nodes;
    // The overflow burst dominates the run; the ceiling leaves room for the rest.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single transfer: address phase, then data phase, each held until hready.
    task automatic ahb(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr_en;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        @(negedge hclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(r, e);
    endtask
    // Pulses one request source and looks at the nodes while it is high.
    task automatic req(input int k, input logic [7:0] e);
        @(posedge hclk);
        reqs <= 8'h01 << k;
        @(negedge hclk);
        chk(can_irq_nodes, e);
        @(posedge hclk);
        reqs <= 8'h00;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k <= 28; k += 4) rd(k == 28 ? 64 : k, 32'h0000_0000);
        chk({hreadyout, hresp}, 32'h0000_0002);
        wr(32'h0000_0040, 32'hFFFF_FFFF);
        rd(32'h0000_0040, 32'h0000_0000);
        wr(32'h0000_0008, 32'hFFFF_FFFF);
        rd(32'h0000_0008, 32'h0000_7777);
        wr(32'h0000_0000, 32'hFFFF_FFFF);
        rd(32'h0000_0000, 32'h0000_004F);
        wr(32'h0000_0000, 32'h0000_0000);
        // Node B wraps after exactly 65536 bit times, routed to node 5.
        wr(32'h0000_000C, 32'h0000_5000);
        wr(32'h0000_0004, 32'h0000_0049);
        i_can_bus_model_b.burst(65536);
        rd(32'h0000_0004, 32'h0000_00C9);
        rd(32'h0000_0010, 32'h0000_0002);
        chk(seen, 32'h0000_0020);
        chk(irq, 32'h0000_0000);
        wr(32'h0000_0014, 32'h0000_0002);
        chk(irq, 32'h0000_0001);
        wr(32'h0000_0010, 32'h0000_0002);
        chk(irq, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_00C9);
        wr(32'h0000_0004, 32'h0000_0049);
        rd(32'h0000_0004, 32'h0000_0049);
        // Node B stamps at end of frame; each frame adds ten bit times.
        for (int f = 1; f <= 2; f++) begin
            i_can_bus_model_b.frame(1'b0, 1'b1);
            chk(b_time_stamp, 16'd10 * f);
            chk(b_captured_count_valid, 32'h0000_0001);
        end
        chk(b_captured_count_field, 32'h0000_000A);
        // Every pointer value on both nodes for the error, last-error and tx/rx fields; last-error and tx/rx match at i = 2 and 6.
        wr(32'h0000_0018, 32'h0000_003F);
        for (int n = 0; n < 2; n++) begin
            for (int i = 0; i < 8; i++) begin
                wr(8 + 4 * n, i | ((7 - i) << 4) | (((i + 3) % 8) << 8));
                req(n * 4, 8'h01 << i);
                req(n * 4 + 1, 8'h01 << (7 - i));
                req(n * 4 + 2, 8'h01 << ((i + 3) % 8));
                req(n * 4 + 3, 8'h01 << ((i + 3) % 8));
            end
        end
        wr(32'h0000_0018, 32'h0000_0000);
        for (int k = 0; k < 8; k++) req(k, 8'h00);
        // All frame-count modes: foreign, received, then transmitted frame.
        cnt = 16'h0000;
        for (int m = 0; m < 8; m++) begin
            wr(32'h0000_0000, m);
            i_can_bus_model.frame(1'b0, 1'b0);
            chk(a_captured_count_valid, 32'h0000_0000);
            i_can_bus_model.frame(1'b0, 1'b1);
            cap = cnt + m[0] + m[1];
            i_can_bus_model.frame(1'b1, 1'b0);
            chk(a_captured_count_valid, 32'h0000_0001);
            cnt = cnt + m[0] + m[1] + m[2];
            rd(32'h0000_0000, {cnt, 12'h000, m[3:0]});
            chk(a_captured_count_field, cap);
        end
        wr(32'h0000_0000, 32'h0000_0008);
        i_can_bus_model.frame(1'b0, 1'b0);
        chk(a_time_stamp, cnt);
        cnt = cnt + 16'd10;
        rd(32'h0000_0000, {cnt, 16'h0008});
        wr(32'h0000_0000, 32'h0000_0009);
        i_can_bus_model.frame(1'b0, 1'b0);
        cnt = cnt + 16'd10;
        chk(a_time_stamp, cnt);
        stop_test();
    end
endmodule // can_frame_counter_irq_routing_test

// *** frame_counter.v ***
`include "can_fc_defines.vh"

module frame_counter (
    hclk,
    hresetn,
    mode,
    ovf_clear,
    bit_start,
    sof_bit,
    eof_last_bit,
    frame_ok,
    frame_tx_own,
    frame_rx_own,
    count_r,
    sample_r,
    sof_capture_r,
    overflow_flag_r,
    overflow_pulse
);
    input wire hclk;
    input wire hresetn;
    input wire [3:0] mode;
    input wire ovf_clear;
    input wire bit_start;
    input wire sof_bit;
    input wire eof_last_bit;
    input wire frame_ok;
    input wire frame_tx_own;
    input wire frame_rx_own;
    output reg [15:0] count_r;
    output reg [15:0] sample_r;
    output reg [15:0] sof_capture_r;
    output reg overflow_flag_r;
    output wire overflow_pulse;

    wire ts_mode;
    wire foreign;
    wire frame_hit;
    wire inc;

    assign ts_mode = mode[`FC_MODE_TS_BIT];
    // A correct frame that this node neither sent nor took is foreign.
    assign foreign = frame_ok & ~frame_tx_own & ~frame_rx_own;
    // Several matching conditions on one frame still give a single increment.
    assign frame_hit = (foreign & mode[`FC_MODE_FOREIGN_BIT])
        | (frame_ok & frame_rx_own & mode[`FC_MODE_RX_BIT])
        | (frame_ok & frame_tx_own & mode[`FC_MODE_TX_BIT]);
    assign inc = ts_mode ? bit_start : frame_hit;
    assign overflow_pulse = inc & (count_r == 16'hFFFF);

    // Counter, samples and sticky overflow; a new overflow beats a clear.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= 16'h0000;
            sample_r <= 16'h0000;
            sof_capture_r <= 16'h0000;
            overflow_flag_r <= 1'b0;
        end else begin
            if (inc) begin
                count_r <= count_r + 16'h0001;
            end
            if (sof_bit) begin
                sof_capture_r <= count_r;
            end
            if (mode == `FC_MODE_TS_SOF && sof_bit) begin
                sample_r <= count_r;
            end else if (mode == `FC_MODE_TS_EOF && eof_last_bit) begin
                sample_r <= count_r;
            end
            if (overflow_pulse) begin
                overflow_flag_r <= 1'b1;
            end else if (ovf_clear) begin
                overflow_flag_r <= 1'b0;
            end
        end
    end
endmodule // frame_counter

// *** irq_router.v ***
module irq_router (
    sel,
    req,
    nodes
);
    input wire [2:0] sel;
    input wire req;
    output wire [7:0] nodes;

    // One-hot steering: a request lands on exactly one node.
    assign nodes = {7'h00, req} << sel;
endmodule // irq_router
